/* rtl/rcwd_cfg.svh */
// Constants of the RC pin watchdog: addresses, fields, commands and timing
`ifndef RCWD_CFG_SVH
`define RCWD_CFG_SVH

// Register addresses on the special function register bus
`define RCWD_ADDR_CTRL 16'hFE0F
`define RCWD_ADDR_PORT7 16'hFE5C

// Control register fields
`define RCWD_BIT_RUN 0
`define RCWD_BIT_RSEL 1
`define RCWD_BIT_CLR 2
`define RCWD_BIT_HLT 4
`define RCWD_BIT_GP 5
`define RCWD_BIT_FLAG 7

// Port 7 fields that shape the watchdog pin
`define RCWD_BIT_P70_DATA 0
`define RCWD_BIT_P70_DIR 4

// Reset values
`define RCWD_CTRL_RESET 8'h00
`define RCWD_PORT7_RESET 8'h00
`define RCWD_RDATA_RESET 8'h00

// Commands
`define RCWD_CMD_CLEAR 8'h55

// Runaway vectors
`define RCWD_VEC_RESET 16'h0000
`define RCWD_VEC_EXTERNAL_INTERRUPT_ZERO 16'h0003

// Timing: reference clock and instruction cycle in ns
`define RCWD_CLK_NS 4
`define RCWD_TCYC_NS 250
`define RCWD_TCYC_CLKS ((`RCWD_TCYC_NS + `RCWD_CLK_NS - 1) / `RCWD_CLK_NS)
// Stretch window in instruction cycles
`define RCWD_STRETCH_MIN_TCYC 1920
`define RCWD_STRETCH_MAX_TCYC 2048
`define RCWD_STRETCH_TICKS (`RCWD_STRETCH_MIN_TCYC + 1)

`endif

/* rtl/rcwd_pkg.sv */
// Types shared by the RC pin watchdog modules
package rcwd_pkg;

    // Watchdog run state, Gray coded
    typedef enum logic [1:0] {
        RCWD_STOPPED = 2'b00,
        RCWD_RUNNING = 2'b01
    } rcwd_state_t;

endpackage

/* rtl/rcwd_stretch_if.sv */
// Link between the watchdog controller and its pulse stretcher
`timescale 1ns/1ps
interface rcwd_stretch_if;
    logic start;  // One-cycle request to (re)start stretching
    logic active; // High while the stretcher holds discharge

    modport ctrl (output start, input active);
    modport timer (input start, output active);
endinterface

/* rtl/rcwd_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module rcwd_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg; // First stage, read only by second stage
    logic [WIDTH-1:0] q_reg;    // Second stage

    // Refuse a meaningless width
    generate
        if (WIDTH < 1) begin : g_chk
            $error("rcwd_sync width must be at least one");
        end
    endgenerate

    // Both stages clear to low on reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule // rcwd_sync

/* rtl/rcwd_stretch.sv */
// Pulse stretcher: holds discharge a fixed count of instruction cycles
`timescale 1ns/1ps
`include "rcwd_cfg.svh"
module rcwd_stretch #(
    parameter int TCYC_CLKS = `RCWD_TCYC_CLKS,
    parameter int STRETCH_TICKS = `RCWD_STRETCH_TICKS
) (
    input wire logic clk,
    input wire logic rst,
    rcwd_stretch_if.timer link
);
    localparam int DW = $clog2(TCYC_CLKS + 1);
    localparam int CW = $clog2(STRETCH_TICKS + 1);

    logic [DW-1:0] div_reg, div_next; // Instruction cycle divider
    logic [CW-1:0] cnt_reg, cnt_next; // Instruction cycles left
    logic tick;                       // One-cycle enable per instruction cycle

    // Refuse counts the counters cannot serve
    generate
        if (TCYC_CLKS < 1 || STRETCH_TICKS < 1) begin : g_chk
            $error("rcwd_stretch counts must be at least one");
        end
    endgenerate

    assign tick = (div_reg == DW'(TCYC_CLKS - 1));

    // Restart restarts the divider too, so the hold is exact
    always_comb begin
        div_next = div_reg;
        cnt_next = cnt_reg;
        if (link.start) begin
            div_next = '0;
            cnt_next = CW'(STRETCH_TICKS);
        end else if (cnt_reg != '0) begin
            if (tick) begin
                div_next = '0;
                cnt_next = cnt_reg - CW'(1);
            end else begin
                div_next = div_reg + DW'(1);
            end
        end
    end

    // Register the counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
            cnt_reg <= '0;
        end else begin
            div_reg <= div_next;
            cnt_reg <= cnt_next;
        end
    end

    // Active from the cycle after start until the count runs out
    assign link.active = (cnt_reg != '0);
endmodule // rcwd_stretch

/* rtl/rcwd_top.sv */
// RC pin watchdog: control register, pin control and runaway detection
`timescale 1ns/1ps
`include "rcwd_cfg.svh"
module rcwd_top #(
    parameter int TCYC_CLKS = `RCWD_TCYC_CLKS,
    parameter int STRETCH_TICKS = `RCWD_STRETCH_TICKS
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [15:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WE,
    input wire logic SFR_RE,
    output logic [7:0] SFR_RDATA,
    input wire logic STANDBY,
    input wire logic WD_PIN_IN,
    input wire logic WD_PIN_HI,
    output logic WD_PIN_OUT,
    output logic WD_PIN_OE,
    output logic WD_PIN_PULLUP,
    output logic CPU_RESET_REQ,
    output logic EXT_EXTERNAL_INTERRUPT_ZERO_REQ,
    output logic [15:0] RUNAWAY_VECTOR
);

    // Overview of the block
    // - Control register: run, discharge, reset select, stop, flag, spare bit
    // - Stopped: every control bit writable, discharge bit pulls the pin at once
    // - Running: control locked, only the clear command reaches the timer
    // - Clear command arms the stretcher, which holds discharge a fixed time
    // - Runaway: rising high-threshold level, reset by select bit, else interrupt while running
    // - Reset path also stops the watchdog so software can program it again
    // - Standby with stop bit: run, discharge and select bits fall
    // - Port 7 register shapes the pin: open, pulled up or driven low
    // - Port 7 data bit reads the synchronised port-level input
    // - Unmapped reads return zero, unmapped writes are dropped
    // Hazards
    // - Pin levels are asynchronous: both pass two flip-flops before use
    // - A level held high gives one event only: detection is edge based
    // - A pin high at reset release looks like an edge; select is 0 then
    // - Setting the runaway flag wins over a software clear in one cycle
    // Limitations
    // - Hold time is a whole count of divided cycles, set by parameters
    // - Clear command is ignored while the discharge bit is 0
    // - Standby is sampled as a level on the system clock
    // - Event outputs are one-cycle pulses; the vector holds until the next
    // - Only an external reset clears every stored bit

    // Refuse timing values the stretcher cannot serve
    generate
        if (TCYC_CLKS < 1 || STRETCH_TICKS < 1) begin : g_chk
            $error("rcwd_top timing counts must be at least one");
        end
    endgenerate

    // Address match used by both read and write decode
    function automatic logic rcwd_hit(input logic [15:0] addr, input logic [15:0] target);
        rcwd_hit = (addr == target);
    endfunction

    // Watchdog run state
    rcwd_pkg::rcwd_state_t state_reg, state_next;

    // Stored control bits
    logic flag_reg, flag_next; // Runaway flag
    logic gp_reg, gp_next;     // General purpose flag
    logic hlt_reg, hlt_next;   // Standby stop bit
    logic clr_reg, clr_next;   // Discharge enable bit
    logic rsel_reg, rsel_next; // Reset select bit

    // Port 7 control register
    logic [7:0] p7_reg, p7_next;

    // Bus read data, runaway outputs
    logic [7:0] rdata_reg, rdata_next;
    logic rstreq_reg, rstreq_next;
    logic external_interrupt_zero_reg, external_interrupt_zero_next;
    logic [15:0] vec_reg, vec_next;

    // Edge detection on the synchronised high-threshold level
    logic hi_last_reg, hi_last_next;

    // Synchronised pin levels
    logic [1:0] pin_sync;
    logic pin_low_level; // Port-level input after sync
    logic pin_high_level; // High-threshold input after sync

    // Decoded strobes and helpers
    logic ctrl_wr;
    logic p7_wr;
    logic ctrl_rd;
    logic p7_rd;
    logic running;
    logic hi_rise;
    logic [7:0] ctrl_view;
    logic [7:0] p7_view;
    logic discharge;
    logic port_drive_low;

    // Stretcher link
    rcwd_stretch_if stretch_link ();

    // Both pin inputs cross into the clock domain
    rcwd_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(REF_CLK),
        .rst(RST),
        .d({WD_PIN_HI, WD_PIN_IN}),
        .q(pin_sync)
    );

    assign pin_low_level = pin_sync[0];
    assign pin_high_level = pin_sync[1];

    // Discharge hold timer
    rcwd_stretch #(
        .TCYC_CLKS(TCYC_CLKS),
        .STRETCH_TICKS(STRETCH_TICKS)
    ) u_stretch (
        .clk(REF_CLK),
        .rst(RST),
        .link(stretch_link.timer)
    );

    // Bus decode
    assign ctrl_wr = SFR_WE && rcwd_hit(SFR_ADDR, `RCWD_ADDR_CTRL);
    assign p7_wr = SFR_WE && rcwd_hit(SFR_ADDR, `RCWD_ADDR_PORT7);
    assign ctrl_rd = SFR_RE && rcwd_hit(SFR_ADDR, `RCWD_ADDR_CTRL);
    assign p7_rd = SFR_RE && rcwd_hit(SFR_ADDR, `RCWD_ADDR_PORT7);

    // Run state decoded once, used by lock and discharge
    assign running = (state_reg == rcwd_pkg::RCWD_RUNNING);

    // Rising edge of the high-threshold level marks a runaway
    // A level held high gives no second event
    assign hi_rise = pin_high_level && !hi_last_reg;

    // Control register as software sees it, unused bits read low
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[`RCWD_BIT_FLAG] = flag_reg;
        ctrl_view[`RCWD_BIT_GP] = gp_reg;
        ctrl_view[`RCWD_BIT_HLT] = hlt_reg;
        ctrl_view[`RCWD_BIT_CLR] = clr_reg;
        ctrl_view[`RCWD_BIT_RSEL] = rsel_reg;
        ctrl_view[`RCWD_BIT_RUN] = running;
    end

    // Port 7 view: the pin data bit shows the real pin level
    always_comb begin
        p7_view = p7_reg;
        p7_view[`RCWD_BIT_P70_DATA] = pin_low_level;
    end

    // Next-state logic for all control state
    always_comb begin
        state_next = state_reg;
        flag_next = flag_reg;
        gp_next = gp_reg;
        hlt_next = hlt_reg;
        clr_next = clr_reg;
        rsel_next = rsel_reg;
        p7_next = p7_reg;
        rstreq_next = 1'b0;
        external_interrupt_zero_next = 1'b0;
        vec_next = vec_reg;
        stretch_link.start = 1'b0;

        // Control register write
        if (ctrl_wr) begin
            if (running) begin
                // Locked: only the clear command acts, bits untouched
                if (SFR_WDATA == `RCWD_CMD_CLEAR && clr_reg) begin
                    stretch_link.start = 1'b1;
                end
            end else begin
                // Stopped: every bit is writable, discharge acts at once
                flag_next = SFR_WDATA[`RCWD_BIT_FLAG];
                gp_next = SFR_WDATA[`RCWD_BIT_GP];
                hlt_next = SFR_WDATA[`RCWD_BIT_HLT];
                clr_next = SFR_WDATA[`RCWD_BIT_CLR];
                rsel_next = SFR_WDATA[`RCWD_BIT_RSEL];
                // Only a one in the run bit changes state
                if (SFR_WDATA[`RCWD_BIT_RUN]) begin
                    state_next = rcwd_pkg::RCWD_RUNNING;
                    // Starting write with discharge also arms the hold
                    stretch_link.start = SFR_WDATA[`RCWD_BIT_CLR];
                end
            end
        end

        // Port 7 control write
        if (p7_wr) begin
            p7_next = SFR_WDATA;
        end

        // Standby entry with the stop bit set stops the watchdog
        if (STANDBY && hlt_reg) begin
            state_next = rcwd_pkg::RCWD_STOPPED;
            clr_next = 1'b0;
            rsel_next = 1'b0;
        end

        // Runaway handling; the set wins over a software clear
        if (hi_rise) begin
            if (rsel_reg) begin
                // Reset path acts whether running or not
                flag_next = 1'b1;
                rstreq_next = 1'b1;
                vec_next = `RCWD_VEC_RESET;
                state_next = rcwd_pkg::RCWD_STOPPED;
                clr_next = 1'b0;
                rsel_next = 1'b0;
            end else if (running) begin
                // Interrupt path, flag untouched
                external_interrupt_zero_next = 1'b1;
                vec_next = `RCWD_VEC_EXTERNAL_INTERRUPT_ZERO;
            end
        end
    end

    // Register all control state; the reset pin clears everything
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= rcwd_pkg::RCWD_STOPPED;
            flag_reg <= 1'b0;
            gp_reg <= 1'b0;
            hlt_reg <= 1'b0;
            clr_reg <= 1'b0;
            rsel_reg <= 1'b0;
            p7_reg <= `RCWD_PORT7_RESET;
            rstreq_reg <= 1'b0;
            external_interrupt_zero_reg <= 1'b0;
            vec_reg <= `RCWD_VEC_RESET;
        end else begin
            state_reg <= state_next;
            flag_reg <= flag_next;
            gp_reg <= gp_next;
            hlt_reg <= hlt_next;
            clr_reg <= clr_next;
            rsel_reg <= rsel_next;
            p7_reg <= p7_next;
            rstreq_reg <= rstreq_next;
            external_interrupt_zero_reg <= external_interrupt_zero_next;
            vec_reg <= vec_next;
        end
    end

    // Read data: latched on the read strobe, unmapped reads zero
    always_comb begin
        rdata_next = rdata_reg;
        if (ctrl_rd) begin // Control register view
            rdata_next = ctrl_view;
        end else if (p7_rd) begin // Port 7 view with live pin bit
            rdata_next = p7_view;
        end else if (SFR_RE) begin // Unmapped address reads zero
            rdata_next = `RCWD_RDATA_RESET;
        end
    end

    // Register read data; it stands until the next read strobe
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_reg <= `RCWD_RDATA_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Edge detector: remembers the synchronised high level of last cycle
    always_comb begin
        hi_last_next = pin_high_level; // Follows the level one cycle late
    end

    // Register the last level; clears low like an idle pin
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            hi_last_reg <= 1'b0;
        end else begin
            hi_last_reg <= hi_last_next;
        end
    end

    // A hold already started runs out even if the watchdog stops
    // Discharge: bit or a running hold when stopped, stretcher alone when running
    assign discharge = stretch_link.active || (clr_reg && !running);

    // Port drives low only with direction 1 and data 0; 00 and 11 stay open
    assign port_drive_low = p7_reg[`RCWD_BIT_P70_DIR] && !p7_reg[`RCWD_BIT_P70_DATA];

    // Open-drain pin: only ever pulls low
    assign WD_PIN_OUT = 1'b0;
    assign WD_PIN_OE = discharge || port_drive_low;

    // Pull-up with direction 0 and data 1
    assign WD_PIN_PULLUP = !p7_reg[`RCWD_BIT_P70_DIR] && p7_reg[`RCWD_BIT_P70_DATA];

    // Registered outputs
    assign SFR_RDATA = rdata_reg;
    assign CPU_RESET_REQ = rstreq_reg;
    assign EXT_EXTERNAL_INTERRUPT_ZERO_REQ = external_interrupt_zero_reg;
    assign RUNAWAY_VECTOR = vec_reg;

endmodule // rcwd_top

/* rtl/README_never.sv */
// (intentionally none)

/* test/rcwd_rc_net.sv */
// Behavioural RC timing network hung on the watchdog pin
`timescale 1ns/1ps
module rcwd_rc_net #(
    parameter int LO_TH = 8, // Port input threshold in charge steps
    parameter int HI_TH = 40 // Slower than the bench clearing interval
) (
    input wire logic clk,
    input wire logic oe,
    input wire logic pull_en,
    input wire logic res_fit,
    output logic pin_in,
    output logic pin_hi
);
    int level = 0; // Capacitor charge in steps
    // Discharge through the pin transistor, else charge through resistor or pull-up
    always @(posedge clk) begin
        if (oe)
            level <= (level > 4) ? level - 4 : 0;
        else if ((res_fit || pull_en) && level < HI_TH + 4)
            level <= level + 1;
    end
    // Two comparators with different thresholds
    assign pin_in = (level > LO_TH);
    assign pin_hi = (level >= HI_TH);
endmodule // rcwd_rc_net

/* test/rcwd_monitor.sv */
// Port-level checker of the RC pin watchdog, bound to its top
`timescale 1ns/1ps
`include "rcwd_cfg.svh"
module rcwd_monitor #(
    parameter int TCYC_CLKS = 2,
    parameter int STRETCH_TICKS = 3
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [15:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WE,
    input wire logic SFR_RE,
    input wire logic [7:0] SFR_RDATA,
    input wire logic STANDBY,
    input wire logic WD_PIN_IN,
    input wire logic WD_PIN_HI,
    input wire logic WD_PIN_OUT,
    input wire logic WD_PIN_OE,
    input wire logic WD_PIN_PULLUP,
    input wire logic CPU_RESET_REQ,
    input wire logic EXT_EXTERNAL_INTERRUPT_ZERO_REQ,
    input wire logic [15:0] RUNAWAY_VECTOR
);
    // One clock domain, checks off during reset
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // Pin below the high threshold for three samples
    sequence s_pin_quiet;
        !WD_PIN_HI [*3];
    endsequence
    // Event pulse of either kind
    sequence s_event;
        CPU_RESET_REQ || EXT_EXTERNAL_INTERRUPT_ZERO_REQ;
    endsequence
    a_drive_low: assert property (WD_PIN_OUT == 1'b0)
        else $error("pin data output not low");
    a_hi_cause: assert property (s_event |-> $past(WD_PIN_HI, 3))
        else $error("event without high pin");
    a_hi_quiet: assert property (s_pin_quiet |=> !CPU_RESET_REQ && !EXT_EXTERNAL_INTERRUPT_ZERO_REQ)
        else $error("event while pin low");
    // Write one cycle back that may pull the pin low: control, or port 7 driving low
    sequence s_oe_write;
        $past(SFR_WE) && ($past(SFR_ADDR) == `RCWD_ADDR_CTRL ||
            ($past(SFR_ADDR) == `RCWD_ADDR_PORT7 && $past(SFR_WDATA[`RCWD_BIT_P70_DIR])
            && !$past(SFR_WDATA[`RCWD_BIT_P70_DATA])));
    endsequence
    a_oe_cause: assert property ($rose(WD_PIN_OE) |-> s_oe_write)
        else $error("discharge without control write");
    a_pullup_mode: assert property (SFR_WE && SFR_ADDR == `RCWD_ADDR_PORT7 |=>
        WD_PIN_PULLUP == (($past(SFR_WDATA) & 8'h11) == 8'h01))
        else $error("pull-up mode wrong");
    a_reset_vector: assert property (CPU_RESET_REQ |-> RUNAWAY_VECTOR == `RCWD_VEC_RESET)
        else $error("reset vector wrong");
    a_int_vector: assert property (EXT_EXTERNAL_INTERRUPT_ZERO_REQ |-> RUNAWAY_VECTOR == `RCWD_VEC_EXTERNAL_INTERRUPT_ZERO)
        else $error("interrupt vector wrong");
    a_reset_single: assert property (CPU_RESET_REQ |=> !CPU_RESET_REQ)
        else $error("reset pulse too long");
    a_one_event: assert property (!(CPU_RESET_REQ && EXT_EXTERNAL_INTERRUPT_ZERO_REQ))
        else $error("reset and interrupt together");
    a_vector_hold: assert property (!CPU_RESET_REQ && !EXT_EXTERNAL_INTERRUPT_ZERO_REQ |->
        $stable(RUNAWAY_VECTOR))
        else $error("vector moved without event");
endmodule // rcwd_monitor

bind rcwd_top rcwd_monitor #(.TCYC_CLKS(TCYC_CLKS), .STRETCH_TICKS(STRETCH_TICKS))
    rcwd_monitor_inst (.REF_CLK(REF_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA),
    .STANDBY(STANDBY), .WD_PIN_IN(WD_PIN_IN), .WD_PIN_HI(WD_PIN_HI),
    .WD_PIN_OUT(WD_PIN_OUT), .WD_PIN_OE(WD_PIN_OE), .WD_PIN_PULLUP(WD_PIN_PULLUP),
    .CPU_RESET_REQ(CPU_RESET_REQ), .EXT_EXTERNAL_INTERRUPT_ZERO_REQ(EXT_EXTERNAL_INTERRUPT_ZERO_REQ),
    .RUNAWAY_VECTOR(RUNAWAY_VECTOR));

/* test/tb_rc_pin_watchdog.sv */
// Self-checking bench of the RC pin watchdog with its RC network
`timescale 1ns/1ps
`include "rcwd_cfg.svh"
module tb_rc_pin_watchdog;
    localparam int TCYC = 2; // Shortened instruction cycle
    localparam int TICKS = 3; // Shortened stretch count
    logic REF_CLK = 1'b0, RST = 1'b1, SFR_WE = 1'b0, SFR_RE = 1'b0, STANDBY = 1'b0;
    logic res_fit = 1'b0, re_d = 1'b0; // Resistor fitted, read taken
    logic WD_PIN_IN, WD_PIN_HI, WD_PIN_OUT, WD_PIN_OE, WD_PIN_PULLUP;
    logic CPU_RESET_REQ, EXT_EXTERNAL_INTERRUPT_ZERO_REQ;
    logic [15:0] SFR_ADDR = 16'h0000, RUNAWAY_VECTOR, rnd;
    logic [7:0] SFR_WDATA = 8'h00, SFR_RDATA, v;
    logic [7:0] exp_q[$]; // Expected read data, oldest first
    int failures = 0, n_compared = 0, run_len = 0, last_run = 0;

    rcwd_top #(.TCYC_CLKS(TCYC), .STRETCH_TICKS(TICKS)) rcwd_top_inst (
        .REF_CLK(REF_CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
        .SFR_WE(SFR_WE), .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA), .STANDBY(STANDBY),
        .WD_PIN_IN(WD_PIN_IN), .WD_PIN_HI(WD_PIN_HI), .WD_PIN_OUT(WD_PIN_OUT),
        .WD_PIN_OE(WD_PIN_OE), .WD_PIN_PULLUP(WD_PIN_PULLUP),
        .CPU_RESET_REQ(CPU_RESET_REQ), .EXT_EXTERNAL_INTERRUPT_ZERO_REQ(EXT_EXTERNAL_INTERRUPT_ZERO_REQ),
        .RUNAWAY_VECTOR(RUNAWAY_VECTOR));
    rcwd_rc_net rcwd_rc_net_inst (.clk(REF_CLK), .oe(WD_PIN_OE), .pull_en(WD_PIN_PULLUP),
        .res_fit(res_fit), .pin_in(WD_PIN_IN), .pin_hi(WD_PIN_HI));

    // 250 MHz reference clock
    initial begin
        forever #2 REF_CLK = ~REF_CLK;
    end
    // Pseudo-random byte source
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Verdict and end of run
    task automatic wrap_up();
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Compare one value
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Register write, one strobe cycle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        SFR_ADDR <= a;
        SFR_WDATA <= d;
        SFR_WE <= 1'b1;
        @(posedge REF_CLK);
        SFR_WE <= 1'b0;
        @(negedge REF_CLK); // Outputs of the write have settled here
    endtask
    // Register read; the watcher compares the answer
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge REF_CLK);
        SFR_ADDR <= a;
        SFR_RE <= 1'b1;
        @(posedge REF_CLK);
        SFR_RE <= 1'b0;
        @(posedge REF_CLK);
    endtask
    // Bounded wait: 0 pin low, 1 interrupt, 2 reset, 3 discharge off
    task automatic wait_for(input int which, input int lim);
        for (int i = 0; i <= lim; i++) begin
            @(negedge REF_CLK);
            if ((which == 0 && WD_PIN_IN === 1'b0) || (which == 1 && EXT_EXTERNAL_INTERRUPT_ZERO_REQ === 1'b1)
                || (which == 2 && CPU_RESET_REQ === 1'b1) || (which == 3 && WD_PIN_OE === 1'b0))
                return;
        end
        failures++;
        wrap_up();
    endtask
    // Discharge the pin and confirm it reads low
    task automatic discharge();
        wr(`RCWD_ADDR_CTRL, 8'h04);
        chk({15'h0000, WD_PIN_OE}, 16'h0001);
        wait_for(0, 100);
        repeat (3) @(posedge REF_CLK);
        rd(`RCWD_ADDR_PORT7, 8'h00);
    endtask
    // Read answers come one cycle after the strobe
    always @(posedge REF_CLK) re_d <= SFR_RE;
    always @(negedge REF_CLK) begin
        if (re_d)
            chk({8'h00, SFR_RDATA}, {8'h00, exp_q.pop_front()});
    end
    // Length of the last discharge run
    always @(negedge REF_CLK) begin
        if (WD_PIN_OE === 1'b1) begin
            run_len++;
        end else if (run_len != 0) begin
            last_run = run_len;
            run_len = 0;
        end
    end
    // Main sequence
    initial begin
        rnd = 16'hA683;
        repeat (4) @(posedge REF_CLK);
        RST <= 1'b0;
        rd(`RCWD_ADDR_CTRL, 8'h00);
        rd(16'hFE10, 8'h00);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            v = {rnd[7:5], i[1], rnd[3:1], i[0]};
            wr(`RCWD_ADDR_PORT7, v);
            chk({15'h0000, WD_PIN_PULLUP}, {15'h0000, v[0] & ~v[4]});
            chk({15'h0000, WD_PIN_OE}, {15'h0000, v[4] & ~v[0]});
            rd(`RCWD_ADDR_PORT7, {v[7:1], 1'b0});
        end
        wr(`RCWD_ADDR_PORT7, 8'h00);
        res_fit <= 1'b1;
        repeat (60) @(posedge REF_CLK);
        rd(`RCWD_ADDR_PORT7, 8'h01);
        discharge();
        wr(`RCWD_ADDR_CTRL, 8'h35); // Start, interrupt on runaway
        rd(`RCWD_ADDR_CTRL, 8'h35);
        wr(`RCWD_ADDR_CTRL, 8'h00);
        wr(`RCWD_ADDR_CTRL, 8'hDA);
        rd(`RCWD_ADDR_CTRL, 8'h35);
        repeat (4) begin
            repeat (14) @(posedge REF_CLK);
            wr(`RCWD_ADDR_CTRL, `RCWD_CMD_CLEAR);
            wait_for(3, 50);
            @(posedge REF_CLK);
            chk(16'(last_run), 16'(TCYC * TICKS));
        end
        rd(`RCWD_ADDR_CTRL, 8'h35);
        wait_for(1, 300);
        chk(RUNAWAY_VECTOR, `RCWD_VEC_EXTERNAL_INTERRUPT_ZERO);
        rd(`RCWD_ADDR_CTRL, 8'h35);
        @(posedge REF_CLK);
        STANDBY <= 1'b1;
        @(posedge REF_CLK);
        STANDBY <= 1'b0;
        rd(`RCWD_ADDR_CTRL, 8'h30);
        discharge(); // Reprogram after standby stop
        wr(`RCWD_ADDR_CTRL, 8'h02); // Reset on runaway, stopped, discharge off
        chk({15'h0000, WD_PIN_OE}, 16'h0000);
        wait_for(2, 300);
        chk(RUNAWAY_VECTOR, `RCWD_VEC_RESET);
        rd(`RCWD_ADDR_CTRL, 8'h80);
        repeat (20) @(posedge REF_CLK);
        rd(`RCWD_ADDR_CTRL, 8'h80);
        wr(`RCWD_ADDR_CTRL, 8'h20);
        rd(`RCWD_ADDR_CTRL, 8'h20);
        RST <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        RST <= 1'b0;
        rd(`RCWD_ADDR_CTRL, 8'h00);
        wrap_up();
    end
endmodule // tb_rc_pin_watchdog
